// File: rtl/mcs_top.sv
`timescale 1ns/1ps
module mcs_top
  import mcs_pkg::*;
#(
  parameter int TICK_CYCLES = CLK_HZ * TICK_SEC,
  parameter int DATA_W      = 16
)(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Keypad pins
  input  wire logic              key_enter,
  input  wire logic              key_up,
  input  wire logic              key_down,
  // Display
  output logic                   disp_blank_o,
  output logic                   disp_query_o,
  output logic      [3:0]        disp_count_o,
  output logic                   edit_unlocked_o,
  // Acquisition
  input  wire logic [DATA_W-1:0] ana_data,
  input  wire logic              ana_valid,
  input  wire logic signed [15:0] wind_sin,
  input  wire logic signed [15:0] wind_cos,
  input  wire logic              precip_pulse,
  output logic                   meas_strobe_o,
  output logic                   poll_strobe_o,
  output logic                   wind_dir_strobe_o,
  // Auxiliary ports
  output logic                   port_b_en_o,
  output logic                   port_c_en_o,
  output mcs_class_t             port_b_class_o,
  output mcs_class_t             port_c_class_o,
  output logic                   port_b_first_o,
  // Record memory
  output logic                   mean_we_o,
  output logic      [15:0]       mean_addr_o,
  output logic      [63:0]       mean_data_o,
  output logic                   ext_we_o,
  output logic      [15:0]       ext_addr_o,
  output logic      [31:0]       ext_data_o
);
  // ==========================================================================
  // Helper functions.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i])
        o[i*8 +: 8] = n[i*8 +: 8];
    return o;
  endfunction

  function automatic logic [15:0] sdiv(input logic signed [31:0] s, input logic [15:0] c);
    return (c == 16'h0000) ? 16'h0000 : 16'(s / $signed({16'h0000, c}));
  endfunction

  // ==========================================================================
  // Pin synchronisers and one-second tick.
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic        rain_prev_reg;
  logic        enter_prev_reg;
  logic [31:0] tick_cnt_reg;
  wire         k_enter = sync2_reg[0];
  wire         k_up    = sync2_reg[1];
  wire         k_down  = sync2_reg[2];
  wire         rain_s  = sync2_reg[3];
  wire         tick    = tick_cnt_reg == 32'(TICK_CYCLES - 1);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_reg      <= 4'h0;
      sync2_reg      <= 4'h0;
      rain_prev_reg  <= 1'b0;
      enter_prev_reg <= 1'b0;
      tick_cnt_reg   <= 32'h0000_0000;
    end
    else
    begin
      sync1_reg      <= {precip_pulse, key_down, key_up, key_enter};
      sync2_reg      <= sync1_reg;
      rain_prev_reg  <= rain_s;
      enter_prev_reg <= k_enter;
      tick_cnt_reg   <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Keypad unlock sequence.
  mcs_key_t   key_reg;
  mcs_key_t   key_next;
  logic [3:0] sec_reg;
  wire        both_keys = k_down & k_up;
  wire        enter_rise = k_enter & ~enter_prev_reg;
  wire        sec_last   = sec_reg == 4'(UNLOCK_SEC - 1);

  always_comb
  begin
    key_next = key_reg;
    unique case (key_reg)
      KEY_IDLE:  if (k_enter && k_down) key_next = KEY_ASK;
      KEY_ASK:   if (both_keys) key_next = KEY_COUNT;
      KEY_COUNT: if (!both_keys) key_next = KEY_ASK;
                 else if (tick && sec_last) key_next = KEY_EDIT;
      KEY_EDIT:  if (enter_rise) key_next = KEY_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      key_reg <= KEY_IDLE;
      sec_reg <= 4'h0;
    end
    else
    begin
      key_reg <= key_next;
      if (key_reg != KEY_COUNT || !both_keys)
        sec_reg <= 4'h0;
      else if (tick)
        sec_reg <= sec_reg + 4'h1;
    end
  end

  assign disp_blank_o    = key_reg == KEY_ASK || key_reg == KEY_COUNT;
  assign disp_query_o    = key_reg == KEY_ASK;
  assign disp_count_o    = (key_reg == KEY_COUNT) ? 4'(UNLOCK_SEC) - sec_reg : 4'h0;
  assign edit_unlocked_o = key_reg == KEY_EDIT;

  // ==========================================================================
  // Wishbone decode and configuration registers.
  mcs_ring_if  mean_if ();
  mcs_ring_if  ext_if ();
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [4:0]  meas_sel_reg;
  logic [3:0]  mean_sel_reg;
  logic [3:0]  ext_sel_reg;
  logic [3:0]  pb_reg;
  logic [3:0]  pc_reg;
  logic        rej_reg;
  logic [31:0] rd_data;
  wire         wb_go    = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire         wb_wr    = wb_go & wb_we_i;
  wire         wr_ctrl  = wb_wr & (wb_adr_i == A_CTRL);
  wire         wr_port  = wb_wr & (wb_adr_i == A_PORT);
  wire         wr_stat  = wb_wr & (wb_adr_i == A_STAT);
  wire [31:0]  ctrl_rd  = {12'h000, ext_sel_reg, 4'h0, mean_sel_reg, 3'h0, meas_sel_reg};
  wire [31:0]  port_rd  = {20'h0_0000, CMD_PORT_CODE, pc_reg, pb_reg};
  wire [31:0]  ctrl_w   = merge(ctrl_rd, wb_dat_i, wb_sel_i);
  wire [31:0]  port_w   = merge(port_rd, wb_dat_i, wb_sel_i);
  wire [4:0]   meas_w   = ctrl_w[MEAS_LSB +: 5];
  wire [3:0]   mean_w   = ctrl_w[MEAN_LSB +: 4];
  wire [3:0]   ext_w    = ctrl_w[EXT_LSB +: 4];
  wire [3:0]   pb_w     = port_w[PB_LSB +: 4];
  wire [3:0]   pc_w     = port_w[PC_LSB +: 4];
  wire         ctrl_ok  = (int'(meas_w) < MEAS_N) && (int'(mean_w) < MEAN_N);
  wire [2:0]   prio_bw  = mcs_prio(pb_w);
  wire         clash    = (prio_bw != 3'h0) && (prio_bw == mcs_prio(pc_w));
  wire         port_ok  = wr_port & ~clash;
  wire         ctrl_bad = wr_ctrl & ~ctrl_ok;
  wire [7:0]   ch_now   = 8'(CH_BASE + mcs_chan(pb_reg) + mcs_chan(pc_reg));
  wire [7:0]   ch_new   = 8'(CH_BASE + mcs_chan(pb_w) + mcs_chan(pc_w));
  wire         reinit   = port_ok & (ch_new != ch_now);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meas_sel_reg <= 5'h00;
      mean_sel_reg <= 4'h0;
      ext_sel_reg  <= 4'h0;
      pb_reg       <= 4'h0;
      pc_reg       <= 4'h0;
      rej_reg      <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && ctrl_ok)
      begin
        meas_sel_reg <= meas_w;
        mean_sel_reg <= mean_w;
        ext_sel_reg  <= ext_w;
      end
      if (port_ok)
      begin
        pb_reg <= pb_w;
        pc_reg <= pc_w;
      end
      if ((wr_port && clash) || ctrl_bad)
        rej_reg <= 1'b1;
      else if (wr_stat && wb_sel_i[0] && wb_dat_i[0])
        rej_reg <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (wb_adr_i)
      A_CTRL:  rd_data = ctrl_rd;
      A_PORT:  rd_data = port_rd;
      A_STAT:  rd_data = {16'h0000, ch_now, 4'h0, ext_if.wrapped, mean_if.wrapped, edit_unlocked_o, rej_reg};
      A_MPTR:  rd_data = {16'h0000, mean_if.ptr};
      A_EPTR:  rd_data = {16'h0000, ext_if.ptr};
      A_MCAP:  rd_data = {16'h0000, mean_if.cap};
      A_ECAP:  rd_data = {16'h0000, ext_if.cap};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= wb_go;
      if (wb_go)
        dat_reg <= rd_data;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ==========================================================================
  // Auxiliary port status.
  wire [2:0] prio_b = mcs_prio(pb_reg);
  wire [2:0] prio_c = mcs_prio(pc_reg);

  assign port_b_en_o    = pb_reg != 4'h0;
  assign port_c_en_o    = pc_reg != 4'h0;
  assign port_b_class_o = !port_b_en_o ? MCS_OFF : (prio_b != 3'h0) ? MCS_SENSOR : MCS_TELEGRAM;
  assign port_c_class_o = !port_c_en_o ? MCS_OFF : (prio_c != 3'h0) ? MCS_SENSOR : MCS_TELEGRAM;
  assign port_b_first_o = (prio_b != 3'h0) && (prio_c == 3'h0 || prio_b < prio_c);

  // ==========================================================================
  // Interval timers.
  logic meas_fire;
  logic mean_fire;
  logic ext_fire;
  wire [14:0] meas_len = 15'(int'(meas_sel_reg) < STEP_N ? mcs_step(int'(meas_sel_reg))
                            : mcs_step(int'(meas_sel_reg) - STEP_N) * SEC_MIN);
  wire [14:0] mean_len = 15'(mcs_step(int'(mean_sel_reg)) * SEC_MIN);
  wire [14:0] ext_len  = 15'(int'(ext_sel_reg) < STEP_N ? mcs_step(int'(ext_sel_reg)) * SEC_MIN
                            : mcs_step(ext_sel_reg == 4'hF ? 5 : int'(ext_sel_reg) - STEP_N) * SEC_HOUR);

  mcs_interval u_meas (.mclk(mclk), .rst(rst), .tick(tick), .len(meas_len), .fire(meas_fire));
  mcs_interval u_mean (.mclk(mclk), .rst(rst), .tick(tick), .len(mean_len), .fire(mean_fire));
  mcs_interval u_ext  (.mclk(mclk), .rst(rst), .tick(tick), .len(ext_len),  .fire(ext_fire));

  // ==========================================================================
  // Accumulators.
  logic [31:0]        ana_sum_reg;
  logic [15:0]        ana_cnt_reg;
  logic signed [31:0] sin_sum_reg;
  logic signed [31:0] cos_sum_reg;
  logic [15:0]        wind_cnt_reg;
  logic [15:0]        rain_reg;
  logic [15:0]        max_reg;
  logic [15:0]        min_reg;
  wire  [15:0]        ana_w    = 16'(ana_data);
  wire                rain_hit = rain_s & ~rain_prev_reg;

  always_ff @(posedge mclk)
  begin
    if (rst || mean_fire)
    begin
      ana_sum_reg  <= 32'h0000_0000;
      ana_cnt_reg  <= 16'h0000;
      sin_sum_reg  <= 32'sh0000_0000;
      cos_sum_reg  <= 32'sh0000_0000;
      wind_cnt_reg <= 16'h0000;
      rain_reg     <= 16'h0000;
    end
    else
    begin
      if (ana_valid)
      begin
        ana_sum_reg <= ana_sum_reg + {16'h0000, ana_w};
        ana_cnt_reg <= ana_cnt_reg + 16'h0001;
      end
      if (tick)
      begin
        sin_sum_reg  <= sin_sum_reg + 32'(wind_sin);
        cos_sum_reg  <= cos_sum_reg + 32'(wind_cos);
        wind_cnt_reg <= wind_cnt_reg + 16'h0001;
      end
      if (rain_hit)
        rain_reg <= rain_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || ext_fire)
    begin
      max_reg <= 16'h0000;
      min_reg <= 16'hFFFF;
    end
    else if (ana_valid)
    begin
      if (ana_w > max_reg)
        max_reg <= ana_w;
      if (ana_w < min_reg)
        min_reg <= ana_w;
    end
  end

  // ==========================================================================
  // Record rings and storage strobes.
  assign mean_if.wr   = mean_fire;
  assign mean_if.init = reinit;
  assign mean_if.cap  = mcs_cap(int'(ch_now), MEAN_K, MEAN_M);
  assign ext_if.wr    = ext_fire;
  assign ext_if.init  = reinit;
  assign ext_if.cap   = mcs_cap(int'(ch_now), EXT_K, EXT_M);

  mcs_ring u_mean_ring (.mclk(mclk), .rst(rst), .r(mean_if.ring));
  mcs_ring u_ext_ring  (.mclk(mclk), .rst(rst), .r(ext_if.ring));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meas_strobe_o     <= 1'b0;
      poll_strobe_o     <= 1'b0;
      wind_dir_strobe_o <= 1'b0;
      mean_we_o         <= 1'b0;
      ext_we_o          <= 1'b0;
      mean_addr_o       <= 16'h0000;
      ext_addr_o        <= 16'h0000;
      mean_data_o       <= 64'h0000_0000_0000_0000;
      ext_data_o        <= 32'h0000_0000;
    end
    else
    begin
      meas_strobe_o     <= meas_fire;
      poll_strobe_o     <= meas_fire;
      wind_dir_strobe_o <= tick;
      mean_we_o         <= mean_fire;
      ext_we_o          <= ext_fire;
      if (mean_fire)
      begin
        mean_addr_o <= mean_if.ptr;
        mean_data_o <= {sdiv(ana_sum_reg, ana_cnt_reg), sdiv(sin_sum_reg, wind_cnt_reg),
                        sdiv(cos_sum_reg, wind_cnt_reg), rain_reg};
      end
      if (ext_fire)
      begin
        ext_addr_o <= ext_if.ptr;
        ext_data_o <= {max_reg, min_reg};
      end
    end
  end

  // ==========================================================================
  // Checks.
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence hold_keys_s;
    (key_reg == KEY_COUNT && both_keys && tick && sec_last);
  endsequence

  wb_ack_a:     assert property (wb_go |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer timing wrong");
  key_ask_a:    assert property (key_reg == KEY_IDLE && k_enter && k_down |=> disp_query_o && disp_blank_o) else $error("no query shown");
  unlock_seq_a: assert property (hold_keys_s |=> edit_unlocked_o && disp_count_o == 4'h0) else $error("unlock not granted");
  early_edit_a: assert property (key_reg == KEY_ASK |=> !edit_unlocked_o) else $error("edit before countdown");
  clash_rej_a:  assert property (wr_port && clash |=> rej_reg && $stable(pb_reg) && $stable(pc_reg)) else $error("clash accepted");
  ring_init_a:  assert property (reinit |=> mean_if.ptr == 16'h0000 && ext_if.ptr == 16'h0000) else $error("rings kept");
  mean_store_a: assert property (mean_fire |=> mean_we_o && mean_addr_o == $past(mean_if.ptr) ##1 !mean_we_o) else $error("mean store");
  ext_store_a:  assert property (ext_fire |=> ext_we_o && ext_data_o == {$past(max_reg), $past(min_reg)}) else $error("ext store");
  wind_tick_a:  assert property (tick |=> wind_dir_strobe_o && !$past(mean_fire) |-> wind_cnt_reg == $past(wind_cnt_reg) + 16'h0001) else $error("wind sample");
  cmd_port_a:   assert property (port_rd[PA_LSB +: 4] == CMD_PORT_CODE) else $error("command port moved");
endmodule

// File: rtl/mcs_pkg.sv
package mcs_pkg;
  // ==========================================================================
  // Contract
  // - On sensor edit entry, blank display line two and show a question mark.
  // - Down and up held together ten seconds, countdown shown, then editing allowed.
  // - Measurement interval offers 23 choices, 1 s up to 60 min.
  // - Each measurement interval samples analogue inputs and polls serial sensors.
  // - Wind and rain inputs run continuously; wind direction sampled every second.
  // - Mean storing interval offers 12 choices, 1 to 60 minutes.
  // - Each mean interval stores the arithmetic mean of its samples.
  // - Wind direction uses a vector mean; precipitation is summed.
  // - Extreme storing interval offers 16 choices, 1 minute up to 6 hours.
  // - Extreme values are written when each extreme interval elapses.
  // - Mean and extreme records use separate rings, oldest overwritten.
  // - Mean ring holds floor(32768 / (5 + 2 * channels)) * 47 records.
  // - Extreme ring holds floor(32768 / (5 + 8 * channels)) * 16 records.
  // - Ports b and c each are off, sensor input or telegram output.
  // - A setting giving both auxiliary ports the same priority is rejected.
  // - A port change that alters the channel count reinitialises both rings.
  // - Keypad port mode editing needs the same ten second unlock.
  // - Sensors are ordered by ascending priority number, lowest first.
  // - Port mode zero means unused, lowest power.
  // - The command serial port stays fixed to command handling.

  // ==========================================================================
  // Timing and memory sizing
  localparam int CLK_HZ     = 50_000_000;
  localparam int TICK_SEC   = 1;
  localparam int UNLOCK_SEC = 10;
  localparam int CH_BASE    = 10;
  localparam int RING_WORDS = 32768;
  localparam int REC_HDR    = 5;
  localparam int MEAN_K     = 2;
  localparam int MEAN_M     = 47;
  localparam int EXT_K      = 8;
  localparam int EXT_M      = 16;
  localparam int MEAS_N     = 23;
  localparam int MEAN_N     = 12;
  localparam int STEP_N     = 11;
  localparam int SEC_MIN    = 60;
  localparam int SEC_HOUR   = 3600;

  // ==========================================================================
  // Register map and fields
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PORT = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_MPTR = 8'h0C;
  localparam logic [7:0] A_EPTR = 8'h10;
  localparam logic [7:0] A_MCAP = 8'h14;
  localparam logic [7:0] A_ECAP = 8'h18;
  localparam int MEAS_LSB = 0;
  localparam int MEAN_LSB = 8;
  localparam int EXT_LSB  = 16;
  localparam int PB_LSB   = 0;
  localparam int PC_LSB   = 4;
  localparam int PA_LSB   = 8;
  localparam int CH_LSB   = 8;
  localparam logic [3:0] CMD_PORT_CODE = 4'h1;

  typedef enum logic [1:0] {MCS_OFF, MCS_SENSOR, MCS_TELEGRAM} mcs_class_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_ASK, KEY_COUNT, KEY_EDIT} mcs_key_t;

  // ==========================================================================
  // Lookup functions
  function automatic int mcs_step(input int i);
    case (i)
      0: return 1;   1: return 2;   2: return 3;   3: return 4;
      4: return 5;   5: return 6;   6: return 10;  7: return 12;
      8: return 15;  9: return 20;  10: return 30; default: return 60;
    endcase
  endfunction

  function automatic int mcs_chan(input logic [3:0] m);
    case (m)
      4'h1: return 3;  4'h2: return 7;  4'h6: return 6;  4'h8: return 6;
      4'h9: return 5;  4'hF: return 10;
      4'h7, 4'hA, 4'hB, 4'hE: return 9;
      default: return 0;
    endcase
  endfunction

  function automatic logic [2:0] mcs_prio(input logic [3:0] m);
    case (m)
      4'h1: return 3'h1;  4'h2: return 3'h2;  4'hF: return 3'h5;
      4'h6, 4'h7, 4'hA, 4'hB, 4'hE: return 3'h3;
      4'h8, 4'h9: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [15:0] mcs_cap(input int ch, input int k, input int m);
    return 16'((RING_WORDS / (REC_HDR + k * ch)) * m);
  endfunction
endpackage

// File: rtl/mcs_ring_if.sv
`timescale 1ns/1ps
interface mcs_ring_if;
  logic        wr;
  logic        init;
  logic [15:0] cap;
  logic [15:0] ptr;
  logic        wrapped;
  modport ctl  (output wr, output init, output cap, input ptr, input wrapped);
  modport ring (input wr, input init, input cap, output ptr, output wrapped);
endinterface

// File: rtl/mcs_interval.sv
`timescale 1ns/1ps
module mcs_interval
  import mcs_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Timing
  input  wire logic        tick,
  input  wire logic [14:0] len,
  output logic             fire
);
  logic [14:0] cnt_reg;
  logic [14:0] cnt_next;
  wire         last = (cnt_reg + 15'h0001) >= len;

  // ==========================================================================
  // Second counter.
  assign fire     = tick & last;
  assign cnt_next = fire ? 15'h0000 : cnt_reg + 15'h0001;

  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_reg <= 15'h0000;
    else if (tick)
      cnt_reg <= cnt_next;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  fire_restart_a: assert property (fire |=> cnt_reg == 15'h0000) else $error("counter kept on fire");
endmodule

// File: rtl/mcs_ring.sv
`timescale 1ns/1ps
module mcs_ring
  import mcs_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Ring control
  mcs_ring_if.ring  r
);
  logic [15:0] ptr_reg;
  logic        wrap_reg;
  wire         at_end = (ptr_reg + 16'h0001) >= r.cap;

  // ==========================================================================
  // Write pointer; the oldest record is overwritten after a wrap.
  always_ff @(posedge mclk)
  begin
    if (rst || r.init)
    begin
      ptr_reg  <= 16'h0000;
      wrap_reg <= 1'b0;
    end
    else if (r.wr)
    begin
      ptr_reg  <= at_end ? 16'h0000 : ptr_reg + 16'h0001;
      wrap_reg <= wrap_reg | at_end;
    end
  end

  assign r.ptr     = ptr_reg;
  assign r.wrapped = wrap_reg;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ring_wrap_a: assert property (r.wr && !r.init && at_end |=> ptr_reg == 16'h0000 && wrap_reg) else $error("ring did not wrap");
  ring_init_a: assert property (r.init |=> ptr_reg == 16'h0000 && !wrap_reg) else $error("ring not cleared");
endmodule

// File: testbench/mcs_operator.sv
`timescale 1ns/1ps
module mcs_operator (
  // Clock
  input  wire logic mclk,
  // Control
  input  wire logic go,
  // Keys
  output logic      key_enter,
  output logic      key_up,
  output logic      key_down
);
  // ==========================================================================
  // Keypad operator: enter with down, then down and up held long.
  int n = 0;
  always @(posedge mclk)
  begin
    n         <= go ? n + 1 : 0;
    key_enter <= go && n < 8;
    key_down  <= go && n < 200;
    key_up    <= go && n >= 12 && n < 200;
  end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import mcs_pkg::*;
  // ==========================================================================
  // Stimulus and checks.
  logic mclk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, go = 0, ana_valid = 0, precip_pulse = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000, q, wb_dat_o, ext_data_o;
  logic [15:0] ana_data = 16'h0000, mean_addr_o, ext_addr_o;
  logic signed [15:0] wind_sin = 0, wind_cos = 0;
  logic [63:0] mean_data_o;
  logic [3:0] disp_count_o;
  logic wb_ack_o, key_enter, key_up, key_down, disp_query_o, edit_unlocked_o, meas_strobe_o;
  logic wind_dir_strobe_o, port_b_en_o, port_b_first_o, mean_we_o, ext_we_o;
  logic disp_blank_o, poll_strobe_o, port_c_en_o;
  mcs_class_t port_b_class_o, port_c_class_o;
  int seed = 45, n_errors = 0, checked = 0, t, np;
  always #10 mclk = ~mclk;
  always @(posedge mclk) ana_valid <= 1'($random(seed));
  mcs_operator op (.mclk, .go, .key_enter, .key_up, .key_down);
  mcs_top #(.TICK_CYCLES(4)) uut (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .key_enter, .key_up, .key_down,
    .disp_blank_o, .disp_query_o, .disp_count_o, .edit_unlocked_o, .ana_data, .ana_valid,
    .wind_sin, .wind_cos, .precip_pulse, .meas_strobe_o, .poll_strobe_o,
    .wind_dir_strobe_o, .port_b_en_o, .port_c_en_o, .port_b_class_o, .port_c_class_o,
    .port_b_first_o, .mean_we_o, .mean_addr_o, .mean_data_o, .ext_we_o, .ext_addr_o,
    .ext_data_o);
  function automatic logic [31:0] cap(int ch, int k, int m);
    return (32768 / (5 + k * ch)) * m;
  endfunction
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0;
    @(posedge mclk);
  endtask
  task automatic wt(ref logic s);
    t = 0;
    do @(posedge mclk); while (s !== 1'b1 && ++t < 600);
    if (t == 600)
      n_errors++;
  endtask
  task automatic final_report;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_errors++;
    final_report;
  end
  initial
  begin
    wind_sin <= 16'($random(seed)); wind_cos <= 16'($random(seed)); ana_data <= 16'($random(seed));
    np = 3 + ($random(seed) & 7);
    repeat (3) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    wb(0, A_MCAP, 0); chk(q, cap(10, 2, 47));
    wb(0, A_ECAP, 0); chk(q, cap(10, 8, 16));
    wb(1, A_PORT, 32'h0000_0076); wb(0, A_STAT, 0); chk(q[0], 1);
    wb(1, A_STAT, 1); wb(1, A_PORT, 32'h0000_0021); wb(0, A_PORT, 0); chk(q[11:0], 12'h121);
    wb(0, A_STAT, 0); chk(q[15:0], 16'h1400);
    wb(0, A_MCAP, 0); chk(q, cap(20, 2, 47));
    chk({port_b_en_o, port_b_class_o, port_b_first_o}, {1'b1, MCS_SENSOR, 1'b1});
    chk({port_c_en_o, port_c_class_o}, {1'b1, MCS_SENSOR});
    wb(1, A_CTRL, 32'h0000_0017); wb(0, A_STAT, 0); chk(q[0], 1);
    wb(1, A_STAT, 1); wb(1, A_CTRL, 32'h000F_0B16); wb(0, A_STAT, 0); chk(q[0], 0);
    $display("register tests finished");
    wb(1, A_CTRL, 32'h0001_0001);
    wt(meas_strobe_o); wt(meas_strobe_o); chk(t + 1, 8); chk(poll_strobe_o, 1);
    wt(wind_dir_strobe_o); wt(wind_dir_strobe_o); chk(t + 1, 4);
    wt(mean_we_o); chk(mean_addr_o, 0); chk(mean_data_o, {ana_data, wind_sin, wind_cos, 16'h0000});
    repeat (np)
    begin
      precip_pulse <= 1; repeat (2) @(posedge mclk);
      precip_pulse <= 0; repeat (2) @(posedge mclk);
    end
    wt(ext_we_o); chk(ext_data_o, {ana_data, ana_data}); chk(ext_addr_o, 0);
    chk({mean_we_o, mean_addr_o, mean_data_o[15:0]}, {1'b1, 16'h0001, 16'(np)});
    wb(0, A_EPTR, 0); chk(q, 1);
    wb(1, A_PORT, 32'h0000_0012); wb(0, A_MPTR, 0); chk(q, 2); chk(port_b_first_o, 0);
    wb(1, A_PORT, 0); wb(0, A_MPTR, 0); chk(q, 0); wb(0, A_EPTR, 0); chk(q, 0);
    chk({port_b_en_o, port_c_en_o, port_c_class_o}, {1'b0, 1'b0, MCS_OFF});
    $display("interval tests finished");
    go <= 1;
    repeat (10) @(posedge mclk); chk({disp_query_o, disp_blank_o}, 2'b11);
    repeat (30) @(posedge mclk); chk(edit_unlocked_o, 0); chk(disp_count_o inside {[4'h1:4'hA]}, 1);
    repeat (60) @(posedge mclk); chk(edit_unlocked_o, 1); chk({disp_blank_o, disp_count_o}, 0);
    $display("keypad tests finished");
    final_report;
  end
endmodule
